// ---- verilog/error_serr_message_gate.sv ----
// Design decision made here: the plain strobed port.
`timescale 1ns/10ps
module error_serr_message_gate
    import err_gate_pkg::*;
(
    input wire logic clock, // 100 MHz clock.
    input wire logic nrst, // Asynchronous reset, active low.
    input wire logic ce, // Clock enable.
    input wire logic [err_gate_pkg::reg_addr_w-1:0] addr, // Register address.
    input wire logic [15:0] wdata, // Write data.
    input wire logic wr, // Write strobe.
    input wire logic rd, // Read strobe.
    output logic [15:0] rdata, // Read data, cycle after rd.
    input wire logic gfx_mode, // Graphics-port mode active.
    input wire logic refresh_overrun, // Event pulse.
    input wire logic hub_target_abort, // Event pulse.
    input wire logic locked_nondram, // Event pulse.
    input wire logic outside_aperture, // Event pulse.
    input wire logic invalid_gfx_access, // Event pulse.
    input wire logic bad_translation_entry, // Event pulse.
    input wire logic bridge_parity_error, // Event pulse.
    input wire logic bridge_target_abort, // Event pulse.
    input wire logic msg_ready, // Hub takes the special cycle.
    output logic msg_valid, // System-error special cycle request.
    output logic [2:0] msg_code, // Source of the message.
    output logic irq // Level interrupt.
);
    import err_gate_pkg::*;

    logic [7:0] error_message_enables;
    logic [15:0] host_command_reg;
    logic [15:0] host_status_reg;
    logic [15:0] bridge_command_reg;
    logic [15:0] bridge_status_reg;
    logic [7:0] bridge_control_reg;
    logic [7:0] bridge_error_enables;
    logic [7:0] irq_status;
    logic [7:0] irq_mask;
    logic [7:0] raw;
    logic [7:0] fire;
    logic prim_ok;
    logic brg_ok;
    logic enables_visible;
    err_event_if evi();

    ////////////////////////////////////////////////////////////////////////////////
    assign raw = {bridge_target_abort, bridge_parity_error, refresh_overrun, hub_target_abort,
                  locked_nondram, outside_aperture, invalid_gfx_access, bad_translation_entry};
    assign prim_ok = host_command_reg[bit_global_msg];
    assign brg_ok = bridge_command_reg[bit_global_msg];
    assign enables_visible = gfx_mode;
    always_comb
    begin
        fire = '0;
        for (int i = 0; i <= bit_refresh; i++)
            fire[i] = raw[i] & error_message_enables[i] & prim_ok;
        fire[bit_bridge_parity] = raw[bit_bridge_parity] & brg_ok & bridge_control_reg[bit_ctrl_parity];
        fire[bit_bridge_abort] = raw[bit_bridge_abort] & brg_ok & bridge_error_enables[bit_bridge_abort_en];
    end

    // One latch per source, so a burst of sources never merges into a single message.
    for (genvar g = 0; g < 8; g++)
    begin : g_lat
        event_latch u_lat
        (
            .clock(clock),
            .nrst(nrst),
            .ce(ce),
            .set(fire[g]),
            .clear(evi.taken[g]),
            .pending(evi.pending[g])
        );
    end

    msg_arbiter u_arb
    (
        .clock(clock),
        .nrst(nrst),
        .ce(ce),
        .ev(evi.arb),
        .msg_ready(msg_ready),
        .msg_valid(msg_valid),
        .msg_code(msg_code)
    );

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            error_message_enables <= enables_reset;
            host_command_reg <= word_reset;
            bridge_command_reg <= word_reset;
            bridge_control_reg <= byte_reset;
            bridge_error_enables <= byte_reset;
            irq_mask <= byte_reset;
        end
        else if (ce && wr)
        begin
            if (addr == off_error_message_enables)
            begin
                if (enables_visible)
                    error_message_enables <= wdata[7:0] & enables_writable;
            end
            else if (addr == off_host_command)
                host_command_reg <= wdata;
            else if (addr == off_bridge_command)
                bridge_command_reg <= wdata;
            else if (addr == off_bridge_control)
                bridge_control_reg <= wdata[7:0];
            else if (addr == off_bridge_error_enables)
                bridge_error_enables <= wdata[7:0];
            else if (addr == off_irq_mask)
                irq_mask <= wdata[7:0];
        end
    end

    // Status flags: write one to clear, a new event in the same cycle wins.
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            host_status_reg <= word_reset;
            bridge_status_reg <= word_reset;
            irq_status <= byte_reset;
        end
        else if (ce)
        begin
            logic [15:0] hs;
            logic [15:0] bs;
            logic [7:0] is;
            hs = host_status_reg;
            bs = bridge_status_reg;
            is = irq_status;
            if (wr && addr == off_host_status)
                hs = hs & ~wdata;
            if (wr && addr == off_bridge_status)
                bs = bs & ~wdata;
            if (wr && addr == off_irq_status)
                is = is & ~wdata[7:0];
            if (fire[bit_refresh:0] != '0)
                hs[bit_sig_serr] = 1'b1;
            if (raw[bit_hub_abort])
                hs[bit_recv_abort] = 1'b1;
            if (fire[bit_bridge_parity] | fire[bit_bridge_abort])
                bs[bit_sig_serr] = 1'b1;
            if (raw[bit_bridge_parity])
                bs[bit_parity_det] = 1'b1;
            if (raw[bit_bridge_abort])
                bs[bit_recv_abort] = 1'b1;
            host_status_reg <= hs;
            bridge_status_reg <= bs;
            irq_status <= is | fire;
        end
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            irq <= 1'b0;
        else if (ce)
            irq <= |(irq_status & irq_mask);
    end

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            rdata <= word_reset;
        else if (ce)
        begin
            rdata <= word_reset;
            if (rd)
            begin
                if (addr == off_error_message_enables)
                    rdata <= enables_visible ? {8'h00, error_message_enables} : word_reset;
                else if (addr == off_host_command)
                    rdata <= host_command_reg;
                else if (addr == off_host_status)
                    rdata <= host_status_reg;
                else if (addr == off_bridge_command)
                    rdata <= bridge_command_reg;
                else if (addr == off_bridge_status)
                    rdata <= bridge_status_reg;
                else if (addr == off_bridge_control)
                    rdata <= {8'h00, bridge_control_reg};
                else if (addr == off_bridge_error_enables)
                    rdata <= {8'h00, bridge_error_enables};
                else if (addr == off_irq_status)
                    rdata <= {8'h00, irq_status};
                else if (addr == off_irq_mask)
                    rdata <= {8'h00, irq_mask};
                else if (addr == off_mode)
                    rdata <= {15'h0000, gfx_mode};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    property p_no_prim_without_global;
        @(posedge clock) disable iff (!nrst) !prim_ok |-> fire[bit_refresh:0] == '0;
    endproperty
    a_no_prim_without_global: assert property (p_no_prim_without_global)
        else $error("primary fired while disabled");

    property p_refresh_gate;
        @(posedge clock) disable iff (!nrst)
            ce && refresh_overrun && prim_ok && error_message_enables[bit_refresh] |=> evi.pending[bit_refresh];
    endproperty
    a_refresh_gate: assert property (p_refresh_gate)
        else $error("refresh overrun not latched");

    property p_refresh_off;
        @(posedge clock) disable iff (!nrst) !error_message_enables[bit_refresh] |-> !fire[bit_refresh];
    endproperty
    a_refresh_off: assert property (p_refresh_off)
        else $error("refresh overrun reported while disabled");

    property p_bridge_off;
        @(posedge clock) disable iff (!nrst) !brg_ok |-> !fire[bit_bridge_parity] && !fire[bit_bridge_abort];
    endproperty
    a_bridge_off: assert property (p_bridge_off)
        else $error("bridge message while disabled");

    sequence s_accept;
        ce && msg_valid && msg_ready;
    endsequence
    property p_single_message;
        @(posedge clock) disable iff (!nrst) s_accept |=> !msg_valid;
    endproperty
    a_single_message: assert property (p_single_message)
        else $error("message not retired after accept");

    property p_hold_message;
        @(posedge clock) disable iff (!nrst) msg_valid && !msg_ready |=> msg_valid && $stable(msg_code);
    endproperty
    a_hold_message: assert property (p_hold_message)
        else $error("message dropped before accept");

    property p_sig_serr;
        @(posedge clock) disable iff (!nrst) ce && fire[bit_hub_abort] |=> host_status_reg[bit_sig_serr];
    endproperty
    a_sig_serr: assert property (p_sig_serr)
        else $error("signalled flag not set");

    property p_recv_abort;
        @(posedge clock) disable iff (!nrst) ce && hub_target_abort |=> host_status_reg[bit_recv_abort];
    endproperty
    a_recv_abort: assert property (p_recv_abort)
        else $error("received abort flag not set");

    property p_enables_reserved;
        @(posedge clock) disable iff (!nrst) error_message_enables[7:6] == 2'b00;
    endproperty
    a_enables_reserved: assert property (p_enables_reserved)
        else $error("reserved enable bits set");
endmodule : error_serr_message_gate

// ---- common/err_gate_pkg.sv ----
package err_gate_pkg;
    localparam int unsigned reg_addr_w = 8;
    localparam int unsigned num_primary = 6;
    // Register byte offsets on the plain port.
    localparam logic [7:0] off_error_message_enables = 8'hcb;
    localparam logic [7:0] off_host_command = 8'h04;
    localparam logic [7:0] off_host_status = 8'h06;
    localparam logic [7:0] off_bridge_command = 8'h44;
    localparam logic [7:0] off_bridge_status = 8'h46;
    localparam logic [7:0] off_bridge_control = 8'h3e;
    localparam logic [7:0] off_bridge_error_enables = 8'h40;
    localparam logic [7:0] off_irq_status = 8'he0;
    localparam logic [7:0] off_irq_mask = 8'he4;
    localparam logic [7:0] off_mode = 8'he8;
    // Event bit positions in the interrupt registers, and for bits 0 to 5 in error_message_enables.
    localparam int unsigned bit_bad_entry = 0;
    localparam int unsigned bit_invalid_gfx = 1;
    localparam int unsigned bit_outside_ap = 2;
    localparam int unsigned bit_locked_nondram = 3;
    localparam int unsigned bit_hub_abort = 4;
    localparam int unsigned bit_refresh = 5;
    localparam int unsigned bit_bridge_parity = 6;
    localparam int unsigned bit_bridge_abort = 7;
    localparam logic [7:0] enables_writable = 8'h3f;
    localparam logic [7:0] enables_reset = 8'h00;
    // Command, status and control bit positions.
    localparam int unsigned bit_global_msg = 8;
    localparam int unsigned bit_sig_serr = 14;
    localparam int unsigned bit_recv_abort = 12;
    localparam int unsigned bit_parity_det = 15;
    localparam int unsigned bit_ctrl_parity = 2;
    localparam int unsigned bit_bridge_abort_en = 0;
    localparam logic [15:0] word_reset = 16'h0000;
    localparam logic [7:0] byte_reset = 8'h00;
endpackage : err_gate_pkg

// ---- common/err_event_if.sv ----
`timescale 1ns/10ps
interface err_event_if;
    logic [7:0] pending; // One bit per event still awaiting its message.
    logic [7:0] taken; // One-cycle pulse: message for that event went out.
    modport arb (input pending, output taken);
    modport src (output pending, input taken);
endinterface : err_event_if

// ---- verilog/event_latch.sv ----
`timescale 1ns/10ps
module event_latch
(
    input wire logic clock, // System clock.
    input wire logic nrst, // Asynchronous reset, active low.
    input wire logic ce, // Clock enable.
    input wire logic set, // Qualified event.
    input wire logic clear, // Message sent.
    output logic pending // Awaiting message.
);
    // A new event in the clear cycle stays pending so it still gets its own message.
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            pending <= 1'b0;
        else if (ce)
            pending <= set | (pending & ~clear);
    end
endmodule : event_latch

// ---- verilog/msg_arbiter.sv ----
`timescale 1ns/10ps
module msg_arbiter
(
    input wire logic clock, // System clock.
    input wire logic nrst, // Asynchronous reset, active low.
    input wire logic ce, // Clock enable.
    err_event_if.arb ev, // Pending events and grant pulses.
    input wire logic msg_ready, // Hub accepts a special cycle.
    output logic msg_valid, // Special cycle offered.
    output logic [2:0] msg_code // Event that caused it.
);
    // One event per message: the latch is cleared only in the accept cycle.
    // The cleared latch is the one named by the offered code, not the lowest one pending now,
    // so an event that arrives while an offer waits cannot take over that offer's acceptance.
    assign ev.taken = (msg_valid && msg_ready) ? (8'h01 << msg_code) : 8'h00;
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            msg_valid <= 1'b0;
            msg_code <= 3'h0;
        end
        else if (ce)
        begin
            if (msg_valid && msg_ready)
                msg_valid <= 1'b0;
            else if (!msg_valid && ev.pending != '0)
            begin
                msg_valid <= 1'b1;
                for (int i = 7; i >= 0; i--)
                    if (ev.pending[i])
                        msg_code <= 3'(i);
            end
        end
    end
endmodule : msg_arbiter

// ---- test/hub_model.sv ----
`timescale 1ns/10ps
// Far side of the message port: takes each special cycle after a chosen stall.
module hub_model
(
    input wire logic clock, // System clock.
    input wire logic nrst, // Asynchronous reset, active low.
    input wire logic [3:0] stall, // Cycles to hold off each offer.
    input wire logic msg_valid, // Special cycle offered.
    input wire logic [2:0] msg_code, // Source of the offer.
    output logic msg_ready, // Offer accepted.
    output int count, // Special cycles taken so far.
    output logic [2:0] last_code // Source of the last one taken.
);
    logic [3:0] waited;

    // Ready only answers an offer, so a stuck-high valid shows up as extra counts.
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            msg_ready <= 1'b0;
            count <= 0;
            last_code <= 3'h0;
            waited <= 4'h0;
        end
        else if (msg_valid && msg_ready)
        begin
            count <= count + 1;
            last_code <= msg_code;
            msg_ready <= 1'b0;
            waited <= 4'h0;
        end
        else if (msg_valid)
        begin
            waited <= waited + 4'h1;
            msg_ready <= (waited >= stall);
        end
    end
endmodule : hub_model

// ---- test/tb_error_serr_message_gate.sv ----
`timescale 1ns/10ps
`define check(got, exp) begin comparisons++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("ERROR %0t: got %h expected %h", $time, got, exp); end end
module tb_error_serr_message_gate;
    import err_gate_pkg::*;
    logic clock = 0, nrst = 0, ce = 1, wr = 0, rd = 0, gfx_mode = 1, msg_valid, msg_ready, irq;
    logic [7:0] addr = 8'h00, ev = 8'h00;
    logic [15:0] wdata = 16'h0000, rdata, val;
    logic [2:0] msg_code, last_code;
    logic [3:0] stall = 4'h0;
    int count, seen, cycles, n_mismatch, comparisons;

    initial forever #5 clock = ~clock;

    error_serr_message_gate error_serr_message_gate_i (.clock(clock), .nrst(nrst), .ce(ce), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .gfx_mode(gfx_mode),
        .refresh_overrun(ev[bit_refresh]), .hub_target_abort(ev[bit_hub_abort]),
        .locked_nondram(ev[bit_locked_nondram]), .outside_aperture(ev[bit_outside_ap]),
        .invalid_gfx_access(ev[bit_invalid_gfx]), .bad_translation_entry(ev[bit_bad_entry]),
        .bridge_parity_error(ev[bit_bridge_parity]), .bridge_target_abort(ev[bit_bridge_abort]),
        .msg_ready(msg_ready), .msg_valid(msg_valid), .msg_code(msg_code), .irq(irq));
    hub_model hub_model_i (.clock(clock), .nrst(nrst), .stall(stall), .msg_valid(msg_valid),
        .msg_code(msg_code), .msg_ready(msg_ready), .count(count), .last_code(last_code));

    ////////////////////////////////////////////////////////////////////////////////
    task finish_test();
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : finish_test

    // The whole run needs a few hundred cycles; this only cuts a hang short.
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_mismatch++;
            finish_test();
        end
    end

    // Bus tasks start just after an edge and leave an idle edge so a strobe is never re-driven at once.
    task wr_reg(input logic [7:0] a, input logic [15:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
        @(posedge clock);
    endtask : wr_reg

    task rd_reg(input logic [7:0] a);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        #1 val = rdata;
        @(posedge clock);
    endtask : rd_reg

    task pulse(input logic [7:0] e);
        ev <= e;
        @(posedge clock);
        ev <= 8'h00;
        @(posedge clock);
    endtask : pulse

    task wait_msg(input logic [2:0] code);
        int n;
        n = 0;
        while (count == seen && n < 50)
        begin
            @(posedge clock);
            n++;
        end
        `check(count, seen + 1)
        `check(last_code, code)
        seen = count;
    endtask : wait_msg

    // A fixed window is the only way to show that nothing more arrives.
    task no_msg();
        repeat (12) @(posedge clock);
        `check(count, seen)
    endtask : no_msg

    ////////////////////////////////////////////////////////////////////////////////
    task t_registers();
        rd_reg(off_error_message_enables);
        `check(val, 16'h0000)
        wr_reg(off_error_message_enables, 16'hffff);
        rd_reg(off_error_message_enables);
        `check(val, 16'h003f)
        gfx_mode <= 1'b0;
        wr_reg(off_error_message_enables, 16'h0000);
        rd_reg(off_error_message_enables);
        `check(val, 16'h0000)
        gfx_mode <= 1'b1;
        rd_reg(off_error_message_enables);
        `check(val, 16'h003f)
        rd_reg(8'h80);
        `check(val, 16'h0000)
        rd_reg(off_mode);
        `check(val, 16'h0001)
        // With the clock enable low a write must leave no trace.
        ce <= 1'b0;
        wr_reg(off_irq_mask, 16'h00aa);
        ce <= 1'b1;
        rd_reg(off_irq_mask);
        `check(val, 16'h0000)
    endtask : t_registers

    // All six events fire together, so only the one enabled source may be reported.
    task t_primary();
        wr_reg(off_host_command, 16'h0100);
        for (int i = 0; i < 6; i++)
        begin
            wr_reg(off_error_message_enables, 16'h0001 << i);
            pulse(8'h3f);
            wait_msg(i[2:0]);
            no_msg();
        end
        rd_reg(off_host_status);
        `check(val, 16'h5000)
        wr_reg(off_host_status, 16'h5000);
        wr_reg(off_host_command, 16'h0000);
        wr_reg(off_error_message_enables, 16'h003f);
        pulse(8'h3f);
        no_msg();
        rd_reg(off_host_status);
        `check(val, 16'h1000)
    endtask : t_primary

    task t_order_slow_hub();
        wr_reg(off_host_command, 16'h0100);
        stall <= 4'h4;
        pulse(8'h28);
        wait_msg(3'h3);
        wait_msg(3'h5);
        no_msg();
        // A lower source arrives while a higher one is still on offer; both must go out once.
        pulse(8'h20);
        pulse(8'h08);
        wait_msg(3'h5);
        wait_msg(3'h3);
        no_msg();
        stall <= 4'h0;
    endtask : t_order_slow_hub

    task t_bridge();
        wr_reg(off_bridge_command, 16'h0100);
        wr_reg(off_bridge_control, 16'h0004);
        wr_reg(off_bridge_error_enables, 16'h0001);
        pulse(8'h40);
        wait_msg(3'h6);
        pulse(8'h80);
        wait_msg(3'h7);
        rd_reg(off_bridge_status);
        `check(val, 16'hd000)
        wr_reg(off_bridge_command, 16'h0000);
        pulse(8'hc0);
        no_msg();
    endtask : t_bridge

    task t_interrupt();
        wr_reg(off_irq_status, 16'h00ff);
        wr_reg(off_irq_mask, 16'h0000);
        wr_reg(off_error_message_enables, 16'h0020);
        pulse(8'h21);
        wait_msg(3'h5);
        `check(irq, 1'b0)
        wr_reg(off_irq_mask, 16'h00ff);
        @(posedge clock);
        `check(irq, 1'b1)
        rd_reg(off_irq_status);
        `check(val, 16'h0020)
        wr_reg(off_irq_status, 16'h0020);
        @(posedge clock);
        `check(irq, 1'b0)
    endtask : t_interrupt

    initial
    begin
        repeat (3) @(posedge clock);
        nrst <= 1'b1;
        @(posedge clock);
        t_registers();
        t_primary();
        t_order_slow_hub();
        t_bridge();
        t_interrupt();
        finish_test();
    end
endmodule : tb_error_serr_message_gate
